/* File: shared/igt_pkg.sv */
// Constants for the floating point and coprocessor gating block.
// Assumes a plain register port and a decode stage that asks each cycle.
// How it works
// RQ1: The 64-bit float enable equals the fpu 64-bit capable bit on revision 2 or later, and is 0 on revision 1.
// RQ2: A 64-bit float instruction decoded while that enable is low raises a reserved instruction exception.
// RQ3: Coprocessor 0 is usable in kernel mode (privilege field 0b00) or in debug mode or at exception or error level.
// RQ4: Coprocessors 1, 2 and 3 are usable exactly when their usable bit in the status register is set; units run 0 to 3.
// RQ5: The coprocessor 2 implemented flag follows the coprocessor 2 present bit of the second configuration register.
// RQ6: The debug port implemented flag equals the debug port present bit of the second configuration register.
// RQ7: With float absent every datatype query gives 0; with it present the any-format query (code 0) gives 1.
// RQ8: With float present the single query gives the single-format bit and the double query the double-format bit.
// RQ9: With float present the word query gives the single-format bit on revision 1 and the word-format bit later.
// RQ10: With float present the long query is true on revision 1 only for architecture type 1 or 2, later the long bit.
// RQ11: With float present the paired-single query is the paired bit and (revision 1 with type 1 or 2, or revision 2+).
// RQ12: Gating follows the current register bits, so a change acts on the next decoded instruction.
package igt_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_FPUID  = 8'h04;
    localparam logic [7:0] OFS_CFG    = 8'h08;
    localparam logic [7:0] OFS_GATE   = 8'h0c;
    localparam logic [7:0] OFS_CAUSE  = 8'h10;
    localparam logic [7:0] OFS_QUERY  = 8'h14;

    // Status register fields
    localparam int ST_PRIV_LSB = 0;
    localparam int ST_EXL      = 2;
    localparam int ST_ERL      = 3;
    localparam int ST_DBG      = 4;
    localparam int ST_CU_LSB   = 5;
    localparam logic [7:0] ST_RESET = 8'h00;

    // FPU identification register fields
    localparam int FI_SINGLE = 0;
    localparam int FI_DOUBLE = 1;
    localparam int FI_PAIRED = 2;
    localparam int FI_WORD   = 3;
    localparam int FI_LONG   = 4;
    localparam int FI_F64    = 5;
    localparam logic [5:0] FI_RESET = 6'h00;

    // Second configuration register fields
    localparam int CF_CP2     = 0;
    localparam int CF_DBGPORT = 1;
    localparam int CF_FLOAT   = 2;
    localparam int CF_AT_LSB  = 3;
    localparam int CF_REV_LSB = 5;
    localparam logic [7:0] CF_RESET = 8'h40;

    // Cause register fields
    localparam int CA_FP64 = 0;
    localparam int CA_COP  = 1;
    localparam int CA_FMT  = 2;
    localparam int CA_CNT_LSB = 8;

    // Query register fields
    localparam int QY_FMT_LSB  = 0;
    localparam int QY_UNIT_LSB = 4;
    localparam logic [5:0] QY_RESET = 6'h00;

    // Datatype query codes
    typedef enum logic [2:0] {
        IGT_FMT_ANY    = 3'h0,
        IGT_FMT_SINGLE = 3'h1,
        IGT_FMT_DOUBLE = 3'h2,
        IGT_FMT_WORD   = 3'h3,
        IGT_FMT_LONG   = 3'h4,
        IGT_FMT_PAIRED = 3'h5
    } igt_fmt_t;

    localparam logic [2:0] REV_FIRST = 3'h1;
    localparam logic [2:0] REV_LATER = 3'h2;
    localparam logic [1:0] AT_TYPE_A = 2'h1;
    localparam logic [1:0] AT_TYPE_B = 2'h2;
    localparam logic [1:0] PRIV_KERNEL = 2'h0;

endpackage

/* File: rtl/igt_cop_check.sv */
// One coprocessor usability check.
// Assumes mode and usable bits come straight from held registers.
`timescale 1ns/100ps
module igt_cop_check #(
    parameter int UNIT = 0
) (
    input  wire logic [1:0] priv_i,
    input  wire logic       dbg_i,
    input  wire logic       exl_i,
    input  wire logic       erl_i,
    input  wire logic       cu_i,
    output logic            usable_o
);
    import igt_pkg::*;

    generate
        if (UNIT == 0) begin : g_kernel
            assign usable_o = (priv_i == PRIV_KERNEL) | dbg_i
                            | exl_i | erl_i; // RQ3
        end else begin : g_cu
            assign usable_o = cu_i; // RQ4
        end
    endgenerate
endmodule

/* File: rtl/igt_fmt_check.sv */
// Floating point datatype query.
// Assumes all inputs but the format code are held register bits.
`timescale 1ns/100ps
module igt_fmt_check (
    input  wire logic [2:0] fmt_i,
    input  wire logic       float_i,
    input  wire logic [2:0] rev_i,
    input  wire logic [1:0] at_i,
    input  wire logic [5:0] fpuid_i,
    output logic            impl_o
);
    import igt_pkg::*;

    logic rev1;
    logic rev2p;
    logic at_ok;

    always_comb begin
        rev1  = (rev_i == REV_FIRST);
        rev2p = (rev_i >= REV_LATER);
        at_ok = (at_i == AT_TYPE_A) || (at_i == AT_TYPE_B);
        impl_o = 1'b0;
        if (float_i) begin // RQ7
            case (fmt_i)
                IGT_FMT_ANY:    impl_o = 1'b1; // RQ7
                IGT_FMT_SINGLE: impl_o = fpuid_i[FI_SINGLE]; // RQ8
                IGT_FMT_DOUBLE: impl_o = fpuid_i[FI_DOUBLE]; // RQ8
                IGT_FMT_WORD:   impl_o = (rev1 & fpuid_i[FI_SINGLE])
                                       | (rev2p & fpuid_i[FI_WORD]); // RQ9
                IGT_FMT_LONG:   impl_o = (rev1 & at_ok)
                                       | (rev2p & fpuid_i[FI_LONG]); // RQ10
                IGT_FMT_PAIRED: impl_o = fpuid_i[FI_PAIRED]
                                       & ((rev1 & at_ok) | rev2p); // RQ11
                default:        impl_o = 1'b0;
            endcase
        end
    end
endmodule

/* File: rtl/igt_gate.sv */
// Floating point and coprocessor gating with its register file.
// Assumes decode asks once per cycle and reads answers one cycle later.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module igt_gate (
    input  wire logic                      clock_i,
    input  wire logic                      nrst_i,
    // Register port
    input  wire logic [igt_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [igt_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic      [igt_pkg::DATA_W-1:0] rdata_o,
    // Decode request
    input  wire logic                      dec_valid_i,
    input  wire logic                      dec_fp64_i,
    input  wire logic                      dec_cop_i,
    input  wire logic [1:0]                dec_unit_i,
    input  wire logic                      dec_fmt_chk_i,
    input  wire logic [2:0]                dec_fmt_i,
    // Gating answers
    output logic                           fp64_en_o,
    output logic      [3:0]                cop_usable_o,
    output logic                           cop2_impl_o,
    output logic                           dbg_port_impl_o,
    output logic                           fmt_impl_o,
    output logic                           ri_exc_o
);
    import igt_pkg::*;

    // Held mode and configuration state
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [5:0] fpuid_q;
    logic [5:0] fpuid_d;
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic [5:0] query_q;
    logic [5:0] query_d;

    // Exception cause tracking
    logic [2:0] cause_q;
    logic [2:0] cause_d;
    logic [7:0] ri_cnt_q;
    logic [7:0] ri_cnt_d;

    // Output registers
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              fp64_en_q;
    logic              fp64_en_d;
    logic [3:0]        cop_usable_q;
    logic [3:0]        cop_usable_d;
    logic              cop2_impl_q;
    logic              cop2_impl_d;
    logic              dbg_impl_q;
    logic              dbg_impl_d;
    logic              fmt_impl_q;
    logic              fmt_impl_d;
    logic              ri_exc_q;
    logic              ri_exc_d;

    // Decoded register fields
    logic [1:0] priv;
    logic       exception_level_bit;
    logic       error_level_bit;
    logic       dbg;
    logic [3:0] cu_bits;
    logic       float_present;
    logic [1:0] arch_type;
    logic [2:0] revision;

    // Live gating terms
    logic       fp64_en;
    logic [3:0] cop_usable;
    logic       dec_fmt_ok;
    logic       qry_fmt_ok;
    logic       qry_cop_ok;
    logic       float_any;

    // Access decode
    logic wr_status;
    logic wr_fpuid;
    logic wr_cfg;
    logic wr_cause;
    logic wr_query;

    // Exception causes this cycle
    logic exc_fp64;
    logic exc_cop;
    logic exc_fmt;
    logic exc_any;

    always_comb begin
        priv          = status_q[ST_PRIV_LSB +: 2];
        exception_level_bit           = status_q[ST_EXL];
        error_level_bit           = status_q[ST_ERL];
        dbg           = status_q[ST_DBG];
        cu_bits       = {status_q[ST_CU_LSB +: 3], 1'b0};
        float_present = cfg_q[CF_FLOAT];
        arch_type     = cfg_q[CF_AT_LSB +: 2];
        revision      = cfg_q[CF_REV_LSB +: 3];
    end

    // 64-bit float enable from revision and capability
    always_comb begin
        if (revision >= REV_LATER) begin
            fp64_en = fpuid_q[FI_F64]; // RQ1
        end else begin
            fp64_en = 1'b0; // RQ1
        end
    end

    // One usability check per coprocessor unit
    genvar u;
    generate
        for (u = 0; u < 4; u++) begin : g_cop
            igt_cop_check #(
                .UNIT     (u)
            ) u_cop (
                .priv_i   (priv),
                .dbg_i    (dbg),
                .exl_i    (exception_level_bit),
                .erl_i    (error_level_bit),
                .cu_i     (cu_bits[u]),
                .usable_o (cop_usable[u])
            );
        end
    endgenerate

    // Datatype check for the instruction being decoded
    igt_fmt_check u_dec_fmt (
        .fmt_i   (dec_fmt_i),
        .float_i (float_present),
        .rev_i   (revision),
        .at_i    (arch_type),
        .fpuid_i (fpuid_q),
        .impl_o  (dec_fmt_ok)
    );

    // Datatype check for the software query
    igt_fmt_check u_qry_fmt (
        .fmt_i   (query_q[QY_FMT_LSB +: 3]),
        .float_i (float_present),
        .rev_i   (revision),
        .at_i    (arch_type),
        .fpuid_i (fpuid_q),
        .impl_o  (qry_fmt_ok)
    );

    // Any-format check gives overall float presence
    igt_fmt_check u_any_fmt (
        .fmt_i   (IGT_FMT_ANY),
        .float_i (float_present),
        .rev_i   (revision),
        .at_i    (arch_type),
        .fpuid_i (fpuid_q),
        .impl_o  (float_any)
    );

    assign qry_cop_ok = cop_usable[query_q[QY_UNIT_LSB +: 2]]; // RQ4

    // Write decode
    always_comb begin
        wr_status = 1'b0;
        wr_fpuid  = 1'b0;
        wr_cfg    = 1'b0;
        wr_cause  = 1'b0;
        wr_query  = 1'b0;
        if (wr_i && addr_i == OFS_STATUS) begin
            wr_status = 1'b1;
        end else if (wr_i && addr_i == OFS_FPUID) begin
            wr_fpuid = 1'b1;
        end else if (wr_i && addr_i == OFS_CFG) begin
            wr_cfg = 1'b1;
        end else if (wr_i && addr_i == OFS_CAUSE) begin
            wr_cause = 1'b1;
        end else if (wr_i && addr_i == OFS_QUERY) begin
            wr_query = 1'b1;
        end
    end

    // Register next values; a write acts on the next decode
    always_comb begin
        status_d = status_q;
        fpuid_d  = fpuid_q;
        cfg_d    = cfg_q;
        query_d  = query_q;
        if (wr_status) begin
            status_d = wdata_i[7:0]; // RQ12
        end
        if (wr_fpuid) begin
            fpuid_d = wdata_i[5:0]; // RQ12
        end
        if (wr_cfg) begin
            cfg_d = wdata_i[7:0]; // RQ12
        end
        if (wr_query) begin
            query_d = wdata_i[5:0];
        end
    end

    // Reserved instruction causes from live gating
    always_comb begin
        exc_fp64 = dec_valid_i & dec_fp64_i & ~fp64_en; // RQ2
        exc_cop  = dec_valid_i & dec_cop_i & ~cop_usable[dec_unit_i];
        exc_fmt  = dec_valid_i & dec_fmt_chk_i & ~dec_fmt_ok;
        exc_any  = exc_fp64 | exc_cop | exc_fmt; // RQ2
    end

    // Sticky causes; a new cause wins over a clear
    always_comb begin
        cause_d  = cause_q;
        ri_cnt_d = ri_cnt_q;
        if (wr_cause) begin
            cause_d  = cause_q & ~wdata_i[2:0];
            ri_cnt_d = 8'h00;
        end
        cause_d[CA_FP64] = cause_d[CA_FP64] | exc_fp64;
        cause_d[CA_COP]  = cause_d[CA_COP] | exc_cop;
        cause_d[CA_FMT]  = cause_d[CA_FMT] | exc_fmt;
        if (exc_any && ri_cnt_d != 8'hff) begin
            ri_cnt_d = ri_cnt_d + 8'h01;
        end
    end

    // Gating answers to decode, registered for timing
    always_comb begin
        fp64_en_d    = fp64_en; // RQ1
        cop_usable_d = cop_usable; // RQ3
        cop2_impl_d  = cfg_q[CF_CP2]; // RQ5
        dbg_impl_d   = cfg_q[CF_DBGPORT]; // RQ6
        fmt_impl_d   = dec_fmt_ok; // RQ8
        ri_exc_d     = exc_any; // RQ2
    end

    // Read data, zero for unmapped addresses
    always_comb begin
        rdata_d = '0;
        if (rd_i && addr_i == OFS_STATUS) begin
            rdata_d[7:0] = status_q;
        end else if (rd_i && addr_i == OFS_FPUID) begin
            rdata_d[5:0] = fpuid_q;
        end else if (rd_i && addr_i == OFS_CFG) begin
            rdata_d[7:0] = cfg_q;
        end else if (rd_i && addr_i == OFS_GATE) begin
            rdata_d[0]   = fp64_en;
            rdata_d[4:1] = cop_usable;
            rdata_d[5]   = cfg_q[CF_CP2];
            rdata_d[6]   = cfg_q[CF_DBGPORT];
            rdata_d[7]   = float_any;
            rdata_d[8]   = qry_fmt_ok;
            rdata_d[9]   = qry_cop_ok;
        end else if (rd_i && addr_i == OFS_CAUSE) begin
            rdata_d[2:0] = cause_q;
            rdata_d[CA_CNT_LSB +: 8] = ri_cnt_q;
        end else if (rd_i && addr_i == OFS_QUERY) begin
            rdata_d[5:0] = query_q;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_q <= ST_RESET;
            fpuid_q  <= FI_RESET;
            cfg_q    <= CF_RESET;
            query_q  <= QY_RESET;
        end else begin
            status_q <= status_d;
            fpuid_q  <= fpuid_d;
            cfg_q    <= cfg_d;
            query_q  <= query_d;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cause_q  <= 3'h0;
            ri_cnt_q <= 8'h00;
        end else begin
            cause_q  <= cause_d;
            ri_cnt_q <= ri_cnt_d;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q      <= '0;
            fp64_en_q    <= 1'b0;
            cop_usable_q <= 4'h0;
            cop2_impl_q  <= 1'b0;
            dbg_impl_q   <= 1'b0;
            fmt_impl_q   <= 1'b0;
            ri_exc_q     <= 1'b0;
        end else begin
            rdata_q      <= rdata_d;
            fp64_en_q    <= fp64_en_d;
            cop_usable_q <= cop_usable_d;
            cop2_impl_q  <= cop2_impl_d;
            dbg_impl_q   <= dbg_impl_d;
            fmt_impl_q   <= fmt_impl_d;
            ri_exc_q     <= ri_exc_d;
        end
    end

    assign rdata_o         = rdata_q;
    assign fp64_en_o       = fp64_en_q;
    assign cop_usable_o    = cop_usable_q;
    assign cop2_impl_o     = cop2_impl_q;
    assign dbg_port_impl_o = dbg_impl_q;
    assign fmt_impl_o      = fmt_impl_q;
    assign ri_exc_o        = ri_exc_q;

endmodule

/* File: bench/igt_gate_assertions.sv */
// Port checker for the gating block.
// Assumes one clock domain and a bind onto igt_gate.
`timescale 1ns/100ps
module igt_gate_assertions (
    input wire logic                        clock_i,
    input wire logic                        nrst_i,
    input wire logic [igt_pkg::ADDR_W-1:0]  addr_i,
    input wire logic [igt_pkg::DATA_W-1:0]  wdata_i,
    input wire logic                        wr_i,
    input wire logic                        dec_valid_i,
    input wire logic                        dec_fp64_i,
    input wire logic                        fp64_en_o,
    input wire logic [3:0]                  cop_usable_o,
    input wire logic                        cop2_impl_o,
    input wire logic                        dbg_port_impl_o,
    input wire logic                        fmt_impl_o,
    input wire logic                        ri_exc_o
);
    import igt_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    logic        cw;
    logic        sw;
    logic [31:0] wd1_q;
    logic [31:0] wd2_q;
    assign cw = wr_i && addr_i == OFS_CFG;
    assign sw = wr_i && addr_i == OFS_STATUS;
    // Write data two edges back, for outputs that lag by two
    always_ff @(posedge clock_i) begin
        wd1_q <= wdata_i;
        wd2_q <= wd1_q;
    end
    property p_rev1_off;
        cw && wdata_i[7:5] == REV_FIRST ##1 !cw |=> !fp64_en_o;
    endproperty
    property p_fp64_exc;
        dec_valid_i && dec_fp64_i && !fp64_en_o && !$past(wr_i) |=> ri_exc_o;
    endproperty
    property p_no_req_no_exc;
        !dec_valid_i |=> !ri_exc_o;
    endproperty
    property p_kernel_cop0;
        sw && wdata_i[1:0] == PRIV_KERNEL ##1 !sw |=> cop_usable_o[0];
    endproperty
    property p_cu_bits;
        sw ##1 !sw |=> cop_usable_o[3:1] == wd2_q[7:5];
    endproperty
    property p_cop2;
        cw ##1 !cw |=> cop2_impl_o == wd2_q[CF_CP2];
    endproperty
    property p_dbg_port;
        cw ##1 !cw |=> dbg_port_impl_o == wd2_q[CF_DBGPORT];
    endproperty
    property p_no_float;
        cw && !wdata_i[CF_FLOAT] ##1 !cw |=> !fmt_impl_o;
    endproperty
    a_rev1_off: assert property (p_rev1_off)
        else $error("fp64 enabled on revision 1");
    a_fp64_exc: assert property (p_fp64_exc)
        else $error("no exception for disabled fp64 op");
    a_no_req_no_exc: assert property (p_no_req_no_exc)
        else $error("exception without request");
    a_kernel_cop0: assert property (p_kernel_cop0)
        else $error("cop0 unusable in kernel mode");
    a_cu_bits: assert property (p_cu_bits)
        else $error("cop usable differs from status");
    a_cop2: assert property (p_cop2)
        else $error("cop2 present mismatch");
    a_dbg_port: assert property (p_dbg_port)
        else $error("debug port mismatch");
    a_no_float: assert property (p_no_float)
        else $error("format reported with float absent");
    c_status: cover property (sw ##1 !sw);
    c_fp64: cover property (dec_valid_i && dec_fp64_i ##1 ri_exc_o);
    c_fmt: cover property (cw && wdata_i[CF_FLOAT] ##2 fmt_impl_o);
endmodule

bind igt_gate igt_gate_assertions u_chk (
    .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .dec_valid_i(dec_valid_i),
    .dec_fp64_i(dec_fp64_i), .fp64_en_o(fp64_en_o),
    .cop_usable_o(cop_usable_o), .cop2_impl_o(cop2_impl_o),
    .dbg_port_impl_o(dbg_port_impl_o), .fmt_impl_o(fmt_impl_o),
    .ri_exc_o(ri_exc_o)
);

/* File: bench/igt_dec_model.sv */
// Decode stage stand-in issuing one request per call.
// Assumes the gate samples requests on the rising edge.
`timescale 1ns/100ps
module igt_dec_model (
    input  wire logic       clock_i,
    output logic            dec_valid_o,
    output logic            dec_fp64_o,
    output logic            dec_cop_o,
    output logic [1:0]      dec_unit_o,
    output logic            dec_fmt_chk_o,
    output logic [2:0]      dec_fmt_o
);
    initial begin
        dec_valid_o = 1'b0;
        dec_fp64_o = 1'b0;
        dec_cop_o = 1'b0;
        dec_unit_o = 2'h0;
        dec_fmt_chk_o = 1'b0;
        dec_fmt_o = 3'h0;
    end
    task automatic issue(input logic f, input logic c, input logic [1:0] u,
                         input logic k, input logic [2:0] m);
        @(posedge clock_i);
        dec_valid_o <= 1'b1;
        dec_fp64_o <= f;
        dec_cop_o <= c;
        dec_unit_o <= u;
        dec_fmt_chk_o <= k;
        dec_fmt_o <= m;
        @(posedge clock_i);
        dec_valid_o <= 1'b0;
        // Stale fields scrambled once idle
        dec_unit_o <= ~u;
        dec_fmt_o <= ~m;
    endtask
endmodule

/* File: bench/igt_gate_tb_top.sv */
// Self-checking bench for the gating block.
// Assumes the decode model and register tasks drive all inputs but clock and reset.
`timescale 1ns/100ps
module igt_gate_tb_top;
    import igt_pkg::*;
    localparam logic [7:0] CFC [4] = '{8'h2f, 8'h37, 8'h5b, 8'h1c};
    logic        clock_i;
    logic        nrst_i;
    logic        wr_i;
    logic        rd_i;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i;
    logic [31:0] rdata_o;
    logic        dv, df, dc, dk;
    logic [1:0]  du;
    logic [2:0]  dm;
    logic        fp64_en_o, cop2_impl_o, dbg_port_impl_o;
    logic        fmt_impl_o, ri_exc_o;
    logic [3:0]  cop_usable_o;
    logic [7:0]  st, cf;
    logic [5:0]  fi;
    logic [3:0]  cu;
    logic        x64;
    logic [5:0]  qy;
    int          ef;
    int          ec;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    igt_gate DUT (
        .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .dec_valid_i(dv), .dec_fp64_i(df), .dec_cop_i(dc),
        .dec_unit_i(du), .dec_fmt_chk_i(dk), .dec_fmt_i(dm),
        .fp64_en_o(fp64_en_o), .cop_usable_o(cop_usable_o),
        .cop2_impl_o(cop2_impl_o), .dbg_port_impl_o(dbg_port_impl_o),
        .fmt_impl_o(fmt_impl_o), .ri_exc_o(ri_exc_o)
    );
    igt_dec_model u_dec (
        .clock_i(clock_i), .dec_valid_o(dv), .dec_fp64_o(df),
        .dec_cop_o(dc), .dec_unit_o(du), .dec_fmt_chk_o(dk),
        .dec_fmt_o(dm)
    );

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    function automatic logic xfmt(input logic [2:0] m);
        logic r1, r2, ta;
        r1 = cf[7:5] == 3'h1;
        r2 = cf[7:5] >= 3'h2;
        ta = cf[4:3] == 2'h1 || cf[4:3] == 2'h2;
        if (!cf[2]) return 1'b0;
        case (m)
            3'h0: return 1'b1;
            3'h1: return fi[0];
            3'h2: return fi[1];
            3'h3: return (r1 & fi[0]) | (r2 & fi[3]);
            3'h4: return (r1 & ta) | (r2 & fi[4]);
            3'h5: return fi[2] & ((r1 & ta) | r2);
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        logic [31:0] d;
        logic        x;
        nrst_i = 1'b0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        void'($urandom(32'h9a4cff81));
        repeat (20) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd(OFS_CFG, d);
        chk(d === 32'h40, "config reset value");
        rd(OFS_STATUS, d);
        chk(d === 32'h0, "status reset value");
        wr(8'h20, 32'hffffffff);
        rd(8'h20, d);
        chk(d === 32'h0, "unmapped read");
        for (int it = 0; it < 150; it++) begin
            st = 8'($urandom);
            fi = 6'($urandom);
            cf = 8'($urandom);
            qy = 6'($urandom);
            if (it < 4) begin
                st = 8'h01;
                fi = 6'h3f;
                cf = CFC[it];
            end
            wr(OFS_STATUS, {24'h0, st});
            wr(OFS_FPUID, {26'h0, fi});
            wr(OFS_CFG, {24'h0, cf});
            wr(OFS_QUERY, {26'h0, qy});
            wr(OFS_GATE, 32'hffffffff);
            x64 = cf[7:5] >= 3'h2 && fi[5];
            cu = {st[7:5], st[1:0] == PRIV_KERNEL || st[4] || st[2] || st[3]};
            #1;
            chk(fp64_en_o === x64, "fp64 enable");
            chk(cop_usable_o === cu, "cop usable");
            chk(cop2_impl_o === cf[0], "cop2 present");
            chk(dbg_port_impl_o === cf[1], "debug port");
            rd(OFS_GATE, d);
            x = d === {22'h0, cu[qy[5:4]], xfmt(qy[2:0]), cf[2:0], cu, x64};
            chk(x, "gate read");
            // Fresh cause record for this round
            wr(OFS_CAUSE, 32'h7);
            ef = 0;
            ec = 0;
            for (int k = 0; k < 8; k++) begin
                u_dec.issue(1'b0, 1'b0, 2'h0, 1'b1, k[2:0]);
                #1;
                x = xfmt(k[2:0]);
                ef = ef + int'(!x);
                chk(fmt_impl_o === x, "format query");
                chk(ri_exc_o === !x, "format exception");
            end
            for (int k = 0; k < 4; k++) begin
                u_dec.issue(1'b0, 1'b1, k[1:0], 1'b0, 3'($urandom));
                #1;
                ec = ec + int'(!cu[k]);
                chk(ri_exc_o === !cu[k], "cop exception");
            end
            u_dec.issue(1'b1, 1'b0, 2'h0, 1'b0, 3'h0);
            #1;
            chk(ri_exc_o === !x64, "fp64 exception");
            rd(OFS_CAUSE, d);
            x = d === {16'h0, 8'(ef + ec + int'(!x64)), 5'h0, ef != 0,
                       ec != 0, !x64};
            chk(x, "cause record");
        end
        tally_and_finish();
    end
endmodule
